// >>> include/cmbi_map.svh
`ifndef CMBI_MAP_SVH
`define CMBI_MAP_SVH
`define CMBI_PAB_W        21
`define CMBI_PDB_W        16
`define CMBI_XAB_W        24
`define CMBI_XDB_W        32
`define CMBI_X2DB_W       16
`define CMBI_IPB_W        16
`define CMBI_XAB_MSB      23
`define CMBI_PRAM_AW      11
`define CMBI_XRAM_AW      12
`define CMBI_XRAM_LANES   4
`define CMBI_LANE_W       8
`define CMBI_BYTE_IDX_LSB 2
`define CMBI_WORD_IDX_LSB 1
`define CMBI_HALF_SEL     0
`define CMBI_PERIPH_BASE  24'hfff000
`define CMBI_PERIPH_MASK  24'hfff000
`define CMBI_FLASH_BASE   21'h100000
`define CMBI_FLASH_MASK   21'h100000
`endif

// >>> include/cmbi_pkg.sv
package cmbi_pkg;
    typedef enum logic [1:0] {
        cmbi_size_byte,
        cmbi_size_word,
        cmbi_size_long
    } cmbi_size_t;
    typedef enum logic [1:0] {
        cmbi_tgt_none,
        cmbi_tgt_ram,
        cmbi_tgt_periph
    } cmbi_tgt_t;
endpackage

// >>> src/cmbi_bridge.sv
`timescale 1ns/10ps
`include "cmbi_map.svh"
// How it works
// - 21-bit program address returns 16-bit program word two cycles later
// - program memory writes take only low 16 bits of write bus
// - 24-bit data address selects byte, word or long; reaches ram and i/o
// - secondary 24-bit word address returns 16-bit data on secondary read bus
// - byte accesses force the top data address bit to zero
// - 16-bit peripheral bus runs at data rate, no wait states
// - primary data ram port 32 bits wide, other data ports 16 bits
// - flash reads/writes on the program bus pass out through one register stage
module cmbi_bridge (
    input  wire logic                       ref_clk,
    input  wire logic                       resetn,
    input  wire logic [`CMBI_PAB_W-1:0]     pab,
    input  wire logic                       p_rd,
    input  wire logic                       p_wr,
    output logic      [`CMBI_PDB_W-1:0]     pdb,
    output logic                            p_flash_rd,
    output logic                            p_flash_wr,
    output logic      [`CMBI_PAB_W-1:0]     p_flash_addr,
    output logic      [`CMBI_PDB_W-1:0]     p_flash_wdata,
    input  wire logic [`CMBI_PDB_W-1:0]     p_flash_rdata,
    input  wire logic [`CMBI_XAB_W-1:0]     primary_data_address,
    input  wire logic                       x_rd,
    input  wire logic                       x_wr,
    input  wire cmbi_pkg::cmbi_size_t       x_size,
    input  wire logic [`CMBI_XDB_W-1:0]     x_wdata,
    output logic      [`CMBI_XDB_W-1:0]     x_rdata,
    input  wire logic [`CMBI_XAB_W-1:0]     secondary_data_address,
    input  wire logic                       x2_rd,
    output logic      [`CMBI_X2DB_W-1:0]    secondary_read_bus,
    output logic                            ipb_rd,
    output logic                            ipb_wr,
    output logic      [`CMBI_XAB_W-1:0]     ipb_addr,
    output logic      [`CMBI_IPB_W-1:0]     ipb_wdata,
    input  wire logic [`CMBI_IPB_W-1:0]     ipb_rdata
);
    logic [`CMBI_XAB_W-1:0]     xa;
    cmbi_pkg::cmbi_tgt_t        tgt;
    logic                       p_flash;
    logic [`CMBI_PDB_W-1:0]     pram [0:(1<<`CMBI_PRAM_AW)-1];
    logic [`CMBI_PDB_W-1:0]     pram_q;
    logic                       p_flash_reg;
    cmbi_pkg::cmbi_tgt_t        tgt_reg;
    logic                       x_rd_reg;
    logic [1:0]                 lane_reg;
    cmbi_pkg::cmbi_size_t       size_reg;
    logic                       x2_rd_reg;
    logic                       x2_hi_reg;
    logic [`CMBI_XRAM_LANES-1:0] be;
    logic [`CMBI_XDB_W-1:0]     wdat;
    logic [`CMBI_XDB_W-1:0]     ram_a;
    logic [`CMBI_XDB_W-1:0]     ram_b;
    logic [`CMBI_XDB_W-1:0]     ram_sh;
    logic [`CMBI_XRAM_AW-1:0]   ram_idx;
    logic [1:0]                 lane;
    logic                       p_rd_reg;

    // byte pointers only reach the lower half of the space
    always_comb begin
        xa = primary_data_address;
        if (x_size == cmbi_pkg::cmbi_size_byte) begin
            xa[`CMBI_XAB_MSB] = 1'b0;
        end
    end

    // bytes were masked first, so they can never land in the peripheral window
    always_comb begin
        if ((xa & `CMBI_PERIPH_MASK) == `CMBI_PERIPH_BASE) begin
            tgt = cmbi_pkg::cmbi_tgt_periph;
        end else begin
            tgt = cmbi_pkg::cmbi_tgt_ram;
        end
    end

    // byte pointers count bytes, word and long pointers count 16-bit words,
    // so long slot n answers to byte address 4n and to word address 2n
    always_comb begin
        if (x_size == cmbi_pkg::cmbi_size_byte) begin
            ram_idx = xa[`CMBI_BYTE_IDX_LSB +: `CMBI_XRAM_AW];
            lane = xa[`CMBI_BYTE_IDX_LSB-1:0];
        end else begin
            ram_idx = xa[`CMBI_WORD_IDX_LSB +: `CMBI_XRAM_AW];
            lane = {xa[`CMBI_HALF_SEL], 1'b0};
        end
    end

    // lanes: word address bit 0 picks the half of a long, a long ignores it
    always_comb begin
        be = '0;
        wdat = x_wdata;
        unique case (x_size)
            cmbi_pkg::cmbi_size_byte: begin
                be[lane] = x_wr;
                wdat = {`CMBI_XRAM_LANES{x_wdata[`CMBI_LANE_W-1:0]}};
            end
            cmbi_pkg::cmbi_size_word: begin
                be = lane[1] ? {x_wr, x_wr, 2'b00} : {2'b00, x_wr, x_wr};
                wdat = {2{x_wdata[15:0]}};
            end
            default: begin
                be = {4{x_wr}};
            end
        endcase
        if (tgt != cmbi_pkg::cmbi_tgt_ram) begin
            be = 4'h0;
        end
    end

    // port b takes word pointers, so it sees the same slots and halves as port a
    cmbi_xram u_xram (
        .ref_clk (ref_clk),
        .a_addr  (ram_idx),
        .a_be    (be),
        .a_wdata (wdat),
        .a_rdata (ram_a),
        .b_addr  (secondary_data_address[`CMBI_WORD_IDX_LSB +: `CMBI_XRAM_AW]),
        .b_rdata (ram_b)
    );

    assign p_flash = (pab & `CMBI_FLASH_MASK) == `CMBI_FLASH_BASE;

    // program ram; writes keep only the low half of the write bus
    always_ff @(posedge ref_clk) begin
        if (p_wr && !p_flash) begin
            pram[pab[`CMBI_PRAM_AW-1:0]] <= x_wdata[`CMBI_PDB_W-1:0];
        end
        pram_q <= pram[pab[`CMBI_PRAM_AW-1:0]];
    end

    // flash array sits outside; strobes and data pass out through one register stage
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            p_flash_rd <= 1'b0;
            p_flash_wr <= 1'b0;
            p_flash_addr <= '0;
            p_flash_wdata <= '0;
            p_flash_reg <= 1'b0;
            p_rd_reg <= 1'b0;
        end else begin
            p_flash_rd <= p_rd && p_flash;
            p_flash_wr <= p_wr && p_flash;
            p_flash_addr <= pab;
            p_flash_wdata <= x_wdata[`CMBI_PDB_W-1:0];
            p_flash_reg <= p_flash;
            p_rd_reg <= p_rd;
        end
    end

    // flash data arrives a cycle after the registered strobe
    // held between reads: an unstrobed flash array drives nothing useful
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pdb <= '0;
        end else if (p_rd_reg) begin
            pdb <= p_flash_reg ? p_flash_rdata : pram_q;
        end
    end

    // peripheral bus: one cycle, same rate as data ram, never stalls the core
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ipb_rd <= 1'b0;
            ipb_wr <= 1'b0;
            ipb_addr <= '0;
            ipb_wdata <= '0;
        end else begin
            ipb_rd <= x_rd && (tgt == cmbi_pkg::cmbi_tgt_periph);
            ipb_wr <= x_wr && (tgt == cmbi_pkg::cmbi_tgt_periph);
            ipb_addr <= xa;
            ipb_wdata <= x_wdata[`CMBI_IPB_W-1:0];
        end
    end

    // request attributes follow the ram's one-cycle read latency
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            tgt_reg <= cmbi_pkg::cmbi_tgt_none;
            x_rd_reg <= 1'b0;
            lane_reg <= 2'b00;
            size_reg <= cmbi_pkg::cmbi_size_word;
            x2_rd_reg <= 1'b0;
            x2_hi_reg <= 1'b0;
        end else begin
            tgt_reg <= tgt;
            x_rd_reg <= x_rd;
            lane_reg <= lane;
            size_reg <= x_size;
            x2_rd_reg <= x2_rd;
            x2_hi_reg <= secondary_data_address[`CMBI_HALF_SEL];
        end
    end

    always_comb begin
        unique case (size_reg)
            cmbi_pkg::cmbi_size_byte: ram_sh = {24'h000000, ram_a[lane_reg*8 +: 8]};
            cmbi_pkg::cmbi_size_word: ram_sh = {16'h0000, lane_reg[1] ? ram_a[31:16] : ram_a[15:0]};
            default:                  ram_sh = ram_a;
        endcase
    end

    // read data is registered, so returns two edges after the request
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            x_rdata <= '0;
        end else if (x_rd_reg) begin
            if (tgt_reg == cmbi_pkg::cmbi_tgt_periph) begin
                x_rdata <= {16'h0000, ipb_rdata};
            end else begin
                x_rdata <= ram_sh;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            secondary_read_bus <= '0;
        end else if (x2_rd_reg) begin
            secondary_read_bus <= x2_hi_reg ? ram_b[31:16] : ram_b[15:0];
        end
    end
endmodule

// >>> src/cmbi_xram.sv
`timescale 1ns/10ps
`include "cmbi_map.svh"
module cmbi_xram (
    input  wire logic                           ref_clk,
    input  wire logic [`CMBI_XRAM_AW-1:0]       a_addr,
    input  wire logic [`CMBI_XRAM_LANES-1:0]    a_be,
    input  wire logic [`CMBI_XDB_W-1:0]         a_wdata,
    output logic      [`CMBI_XDB_W-1:0]         a_rdata,
    input  wire logic [`CMBI_XRAM_AW-1:0]       b_addr,
    output logic      [`CMBI_XDB_W-1:0]         b_rdata
);
    // 32-bit port a, read-only port b for the dual read
    genvar i;
    generate
        for (i = 0; i < `CMBI_XRAM_LANES; i = i + 1) begin : g_lane
            // one array per byte lane, so every lane is written by one process only
            logic [`CMBI_LANE_W-1:0] mem [0:(1<<`CMBI_XRAM_AW)-1];
            always_ff @(posedge ref_clk) begin
                if (a_be[i]) begin
                    mem[a_addr] <= a_wdata[i*`CMBI_LANE_W +: `CMBI_LANE_W];
                end
                a_rdata[i*`CMBI_LANE_W +: `CMBI_LANE_W] <= mem[a_addr];
                b_rdata[i*`CMBI_LANE_W +: `CMBI_LANE_W] <= mem[b_addr];
            end
        end
    endgenerate
endmodule

// >>> test/cmbi_bridge_monitor.sv
`timescale 1ns/10ps
module cmbi_bridge_monitor (
    input wire logic                 ref_clk,
    input wire logic                 resetn,
    input wire logic [20:0]          pab,
    input wire logic                 p_rd,
    input wire logic                 p_wr,
    input wire logic                 p_flash_rd,
    input wire logic                 p_flash_wr,
    input wire logic [20:0]          p_flash_addr,
    input wire logic [15:0]          p_flash_wdata,
    input wire logic [23:0]          primary_data_address,
    input wire logic                 x_rd,
    input wire logic                 x_wr,
    input wire cmbi_pkg::cmbi_size_t x_size,
    input wire logic [31:0]          x_wdata,
    input wire logic                 ipb_rd,
    input wire logic                 ipb_wr,
    input wire logic [23:0]          ipb_addr,
    input wire logic [15:0]          ipb_wdata
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    wire byt = x_size == cmbi_pkg::cmbi_size_byte;
    // bytes can never reach the window since their top bit is cleared
    wire per = primary_data_address[23:12] == 12'hfff && !byt;
    sequence s_per_w;
        x_wr && per;
    endsequence
    a_per_wr_strobe: assert property (s_per_w |=> ipb_wr && ipb_wdata == $past(x_wdata[15:0]))
        else $error("peripheral write strobe or data wrong");
    a_per_one_shot: assert property (s_per_w ##1 !x_wr |=> !ipb_wr)
        else $error("peripheral write strobe too long");
    a_per_rd_addr: assert property (x_rd && per |=> ipb_rd && ipb_addr == $past(primary_data_address))
        else $error("peripheral read strobe or address wrong");
    a_byte_no_per: assert property ((x_rd || x_wr) && byt |=> !ipb_rd && !ipb_wr)
        else $error("byte access reached peripheral bus");
    a_ram_no_per: assert property ((x_rd || x_wr) && !per |=> !ipb_rd && !ipb_wr)
        else $error("ram access reached peripheral bus");
    a_flash_rd_pass: assert property (p_rd && pab[20] |=> p_flash_rd && p_flash_addr == $past(pab))
        else $error("flash read not passed through");
    a_flash_wr_low: assert property (p_wr && pab[20] |=> p_flash_wr && p_flash_wdata == $past(x_wdata[15:0]))
        else $error("flash write data not low half");
    a_pram_local: assert property ((p_rd || p_wr) && !pab[20] |=> !p_flash_rd && !p_flash_wr)
        else $error("program ram access hit flash");
endmodule

// >>> test/cmbi_bridge_tb.sv
`timescale 1ns/10ps
bind cmbi_bridge cmbi_bridge_monitor u_mon (.ref_clk, .resetn, .pab, .p_rd, .p_wr, .p_flash_rd,
    .p_flash_wr, .p_flash_addr, .p_flash_wdata, .primary_data_address, .x_rd, .x_wr, .x_size,
    .x_wdata, .ipb_rd, .ipb_wr, .ipb_addr, .ipb_wdata);
module cmbi_bridge_tb;
    typedef struct {logic [23:0] a; logic [31:0] d;} cmbi_row_t;
    logic ref_clk = 0, resetn = 0, p_rd = 0, p_wr = 0, x_rd = 0, x_wr = 0, x2_rd = 0;
    logic [20:0] pab = 0, fa;
    logic [23:0] xa = 0, xa2 = 0, ia;
    logic [31:0] wd = 0, rd;
    logic [15:0] pdb, s2, frd, ird, fwd;
    logic        fr, ir;
    cmbi_pkg::cmbi_size_t sz = cmbi_pkg::cmbi_size_long;
    int fail_count = 0, num_checks = 0;
    cmbi_row_t rows[3] = '{'{24'h000000, 32'h01234567}, '{24'h000004, 32'h89abcdef},
                           '{24'h003ffc, 32'hfedcba98}};
    cmbi_bridge DUT (.ref_clk, .resetn, .pab, .p_rd, .p_wr, .pdb, .p_flash_rd(fr),
        .p_flash_wr(), .p_flash_addr(fa), .p_flash_wdata(fwd), .p_flash_rdata(frd),
        .primary_data_address(xa), .x_rd, .x_wr, .x_size(sz), .x_wdata(wd), .x_rdata(rd),
        .secondary_data_address(xa2), .x2_rd, .secondary_read_bus(s2), .ipb_rd(ir),
        .ipb_wr(), .ipb_addr(ia), .ipb_wdata(), .ipb_rdata(ird));
    cmbi_far_model u_far (.p_flash_rd(fr), .p_flash_addr(fa), .p_flash_rdata(frd),
        .ipb_rd(ir), .ipb_addr(ia), .ipb_rdata(ird));
    always #2.5 ref_clk = ~ref_clk;
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // op bits: data read, data write, program read, program write, secondary read
    task automatic req(logic [4:0] op, logic [23:0] a, logic [23:0] a2, logic [31:0] d,
                       cmbi_pkg::cmbi_size_t s = cmbi_pkg::cmbi_size_long);
        @(posedge ref_clk);
        {x_rd, x_wr, p_rd, p_wr, x2_rd} <= op;
        xa <= a;
        pab <= a[20:0];
        xa2 <= a2;
        wd <= d;
        sz <= s;
        @(posedge ref_clk);
        {x_rd, x_wr, p_rd, p_wr, x2_rd} <= 5'h00;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        #1 chk({pdb, s2}, 32'h0);
        chk(rd, 32'h0);
        @(posedge ref_clk) resetn <= 1;
        foreach (rows[i]) begin
            req(5'h08, rows[i].a, 24'h0, rows[i].d);
            req(5'h10, rows[i].a, 24'h0, 32'h0);
            chk(rd, rows[i].d);
        end
        $display("ram rows done");
        req(5'h11, 24'h000000, 24'h000004, 32'h0);
        chk(rd, 32'h01234567);
        chk(s2, 16'hcdef);
        req(5'h11, 24'h000004, 24'h000005, 32'h0);
        chk(s2, 16'h89ab);
        $display("dual read done");
        req(5'h08, 24'h000010, 24'h0, 32'h11112222);
        req(5'h08, 24'hfff010, 24'h0, 32'hdead5678);
        req(5'h10, 24'hfff010, 24'h0, 32'h0);
        chk(rd, {16'h0, 16'hf010 ^ 16'ha5a5});
        req(5'h08, 24'hfff020, 24'h0, 32'h000000aa, cmbi_pkg::cmbi_size_byte);
        req(5'h10, 24'h000010, 24'h0, 32'h0);
        chk(rd, 32'h11112222);
        $display("peripheral done");
        req(5'h08, 24'h000020, 24'h0, 32'h11223344);
        req(5'h08, 24'h000021, 24'h0, 32'h0000beef, cmbi_pkg::cmbi_size_word);
        req(5'h10, 24'h000021, 24'h0, 32'h0, cmbi_pkg::cmbi_size_word);
        chk(rd, 32'h0000beef);
        req(5'h10, 24'h000020, 24'h0, 32'h0, cmbi_pkg::cmbi_size_word);
        chk(rd, 32'h00003344);
        req(5'h08, 24'h000042, 24'h0, 32'h0000005a, cmbi_pkg::cmbi_size_byte);
        req(5'h10, 24'h000043, 24'h0, 32'h0, cmbi_pkg::cmbi_size_byte);
        chk(rd, 32'h000000be);
        req(5'h10, 24'hfff020, 24'h0, 32'h0, cmbi_pkg::cmbi_size_byte);
        chk(rd, 32'h000000aa);
        req(5'h10, 24'h000020, 24'h0, 32'h0);
        chk(rd, 32'hbe5a3344);
        $display("size done");
        req(5'h02, 24'h000123, 24'h0, 32'habcd1234);
        req(5'h04, 24'h000123, 24'h0, 32'h0);
        chk(pdb, 16'h1234);
        req(5'h04, 24'h100456, 24'h0, 32'h0);
        chk(pdb, 16'h0456 ^ 16'h5a5a);
        req(5'h02, 24'h100456, 24'h0, 32'h9876fedc);
        chk(fwd, 16'hfedc);
        $display("program done");
        @(posedge ref_clk) resetn <= 0;
        repeat (2) @(posedge ref_clk);
        #1 chk({pdb, s2}, 32'h0);
        chk(rd, 32'h0);
        chk({fr, ir}, 2'b00);
        @(posedge ref_clk) resetn <= 1;
        req(5'h10, 24'h000004, 24'h0, 32'h0);
        chk(rd, 32'h89abcdef);
        $display("mid-run reset done");
        final_report();
    end
endmodule

// >>> test/cmbi_far_model.sv
`timescale 1ns/10ps
module cmbi_far_model (
    input  wire logic        p_flash_rd,
    input  wire logic [20:0] p_flash_addr,
    output logic      [15:0] p_flash_rdata,
    input  wire logic        ipb_rd,
    input  wire logic [23:0] ipb_addr,
    output logic      [15:0] ipb_rdata
);
    // deselected lines show inverted data so a stale capture cannot match
    assign p_flash_rdata = p_flash_rd ? p_flash_addr[15:0] ^ 16'h5a5a : ~p_flash_addr[15:0];
    assign ipb_rdata = ipb_rd ? ipb_addr[15:0] ^ 16'ha5a5 : ~ipb_addr[15:0];
endmodule
